// >>> rtl/ipc_regs.vh
// Register map, field positions and reset values of the interrupt priority block
`ifndef IPC_REGS_VH
`define IPC_REGS_VH

// Byte offsets on the register bus
`define IPC_OFS_PRIO_A     8'h00
`define IPC_OFS_PRIO_B     8'h04
`define IPC_OFS_PRIO_C     8'h08
`define IPC_OFS_PRIO_D     8'h0C
`define IPC_OFS_PRIO_E     8'h10
`define IPC_OFS_MAIN       8'h14
`define IPC_OFS_SECOND     8'h18
`define IPC_OFS_THIRD      8'h1C
`define IPC_OFS_PIN_CHG    8'h20
`define IPC_OFS_CFG        8'h24
`define IPC_OFS_STATUS     8'h28

// Writable masks and reset values
`define IPC_MSK_PRIO_A     8'h7F
`define IPC_RST_PRIO_A     8'h7F
`define IPC_RST_PRIO_B     8'hFF
`define IPC_RST_PRIO_C     8'h00
`define IPC_MSK_PRIO_DE    8'h07
`define IPC_RST_PRIO_DE    8'h00
`define IPC_RST_MAIN       8'h00
`define IPC_MSK_SECOND     8'h75
`define IPC_RST_SECOND     8'h75
`define IPC_MSK_THIRD      8'hDB
`define IPC_RST_THIRD      8'hC0
`define IPC_MSK_PIN_CHG    8'hF0
`define IPC_RST_PIN_CHG    8'h00
`define IPC_MSK_CFG        8'h81
`define IPC_RST_CFG        8'h00

// Main control bits
`define IPC_MAIN_GH        7
`define IPC_MAIN_GL        6
`define IPC_MAIN_T0E       5
`define IPC_MAIN_E0E       4
`define IPC_MAIN_PCE       3
`define IPC_MAIN_T0F       2
`define IPC_MAIN_E0F       1
`define IPC_MAIN_PCF       0
// Second control bits
`define IPC_SEC_EDG0       6
`define IPC_SEC_EDG1       5
`define IPC_SEC_EDG2       4
`define IPC_SEC_T0P        2
`define IPC_SEC_PCP        0
// Third control bits
`define IPC_THR_E2P        7
`define IPC_THR_E1P        6
`define IPC_THR_E2E        4
`define IPC_THR_E1E        3
`define IPC_THR_E2F        1
`define IPC_THR_E1F        0
// Configuration bits
`define IPC_CFG_PMODE      7
`define IPC_CFG_T16        0

`define IPC_T8_MAX         8'hFF
`define IPC_T16_MAX        16'hFFFF
`define IPC_NPER           29
`define IPC_PCW            21
`define IPC_SPW            3

`endif

// >>> rtl/ipc_top.v
// Interrupt priority, external pin, timer-zero and port-change interrupt controller
//
// The Avalon-MM register port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "ipc_regs.vh"

module ipc_top (
	input  wire                   mclk_i,
	input  wire                   rstn_i,
	input  wire [7:0]             avs_address_i,
	input  wire                   avs_read_i,
	input  wire                   avs_write_i,
	input  wire [31:0]            avs_writedata_i,
	output reg  [31:0]            avs_readdata_o,
	output reg                    avs_waitrequest_o,
	input  wire [2:0]             ext_pin_i,
	input  wire [3:0]             port_hi_i,
	input  wire [15:0]            timer_count_i,
	input  wire [`IPC_NPER-1:0]   per_req_i,
	input  wire                   sleep_i,
	input  wire                   entry_i,
	input  wire                   return_i,
	input  wire [`IPC_PCW-1:0]    pc_i,
	input  wire [7:0]             working_register_i,
	input  wire [7:0]             status_i,
	input  wire [7:0]             bsr_i,
	output reg                    irq_high_o,
	output reg                    irq_low_o,
	output reg                    wake_o,
	output reg  [`IPC_PCW-1:0]    ret_pc_o,
	output reg  [7:0]             shadow_working_register_o,
	output reg  [7:0]             shadow_status_o,
	output reg  [7:0]             shadow_bsr_o
);

	reg  [7:0]            prio_a_q;
	reg  [7:0]            prio_b_q;
	reg  [7:0]            prio_c_q;
	reg  [7:0]            prio_d_q;
	reg  [7:0]            prio_e_q;
	reg  [7:0]            main_q;
	reg  [7:0]            second_q;
	reg  [7:0]            third_q;
	reg  [7:0]            pin_chg_q;
	reg  [7:0]            cfg_q;
	reg  [31:0]           rdata_d;
	reg  [2:0]            ext_s1_q;
	reg  [2:0]            ext_s2_q;
	reg  [2:0]            ext_s3_q;
	reg  [3:0]            pb_s1_q;
	reg  [3:0]            pb_s2_q;
	reg  [3:0]            pb_s3_q;
	reg  [15:0]           tprev_q;
	reg                   sleep_q;
	reg  [2:0]            snap_q;
	reg  [`IPC_SPW-1:0]   sp_q;
	reg  [`IPC_PCW-1:0]   stack_mem [0:(1<<`IPC_SPW)-1];

	wire                  wr_en;
	wire                  rd_en;
	wire [2:0]            edge_sel;
	wire [2:0]            ext_rise;
	wire [2:0]            ext_fall;
	wire [2:0]            ext_hit;
	wire [3:0]            pb_chg;
	wire                  t0_ovf;
	wire                  pmode;
	wire [`IPC_NPER-1:0]  prio_vec;
	wire [2:0]            ext_flags;
	wire [2:0]            ext_ens;
	wire                  e0_req;
	wire                  e1_req;
	wire                  e2_req;
	wire                  t0_req;
	wire                  pc_req;
	wire                  gh;
	wire                  gl;
	wire                  hi_any;
	wire                  lo_any;
	wire                  one_any;
	wire [`IPC_SPW-1:0]   sp_dec;

	// Masked write with write-enable, shared by all plain registers
	function [7:0] wmerge;
		input [7:0] cur;
		input [7:0] wd;
		input [7:0] msk;
		input       we;
		begin
			wmerge = we ? (wd & msk) : cur;
		end
	endfunction

	// Bus: one wait state, effect at the edge where waitrequest is low
	assign wr_en = avs_write_i & ~avs_waitrequest_o;
	assign rd_en = avs_read_i | avs_write_i;

	always @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o    <= 32'h0000_0000;
		end else begin
			if (rd_en && avs_waitrequest_o) begin
				avs_waitrequest_o <= 1'b0;
			end else begin
				avs_waitrequest_o <= 1'b1;
			end
			avs_readdata_o <= rdata_d;
		end
	end

	always @* begin
		rdata_d = 32'h0000_0000;
		case (avs_address_i)
			`IPC_OFS_PRIO_A:  rdata_d[7:0] = prio_a_q & `IPC_MSK_PRIO_A;
			`IPC_OFS_PRIO_B:  rdata_d[7:0] = prio_b_q;
			`IPC_OFS_PRIO_C:  rdata_d[7:0] = prio_c_q;
			`IPC_OFS_PRIO_D:  rdata_d[7:0] = prio_d_q & `IPC_MSK_PRIO_DE;
			`IPC_OFS_PRIO_E:  rdata_d[7:0] = prio_e_q & `IPC_MSK_PRIO_DE;
			`IPC_OFS_MAIN:    rdata_d[7:0] = main_q;
			`IPC_OFS_SECOND:  rdata_d[7:0] = second_q;
			`IPC_OFS_THIRD:   rdata_d[7:0] = third_q;
			`IPC_OFS_PIN_CHG: rdata_d[7:0] = pin_chg_q;
			`IPC_OFS_CFG:     rdata_d[7:0] = cfg_q;
			`IPC_OFS_STATUS:  rdata_d[7:0] = {1'b0, sp_q, wake_o, sleep_q, irq_low_o, irq_high_o};
			default:          rdata_d = 32'h0000_0000;
		endcase
	end

	// Pin synchronisers; third stage only feeds edge detection
	always @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ext_s1_q <= 3'h0;
			ext_s2_q <= 3'h0;
			ext_s3_q <= 3'h0;
			pb_s1_q  <= 4'h0;
			pb_s2_q  <= 4'h0;
			pb_s3_q  <= 4'h0;
			tprev_q  <= 16'h0000;
		end else begin
			ext_s1_q <= ext_pin_i;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
			pb_s1_q  <= port_hi_i;
			pb_s2_q  <= pb_s1_q;
			pb_s3_q  <= pb_s2_q;
			tprev_q  <= timer_count_i;
		end
	end

	assign edge_sel = {second_q[`IPC_SEC_EDG2], second_q[`IPC_SEC_EDG1], second_q[`IPC_SEC_EDG0]};
	assign ext_rise = ext_s2_q & ~ext_s3_q;
	assign ext_fall = ~ext_s2_q & ext_s3_q;
	assign ext_hit  = (edge_sel & ext_rise) | (~edge_sel & ext_fall);

	// change on enabled upper port pins
	assign pb_chg = (pb_s2_q ^ pb_s3_q) & pin_chg_q[7:4];

	assign t0_ovf = cfg_q[`IPC_CFG_T16] ?
		((tprev_q == `IPC_T16_MAX) && (timer_count_i == 16'h0000)) :
		((tprev_q[7:0] == `IPC_T8_MAX) && (timer_count_i[7:0] == 8'h00));

	// Register file; hardware set wins over a software write in the same cycle
	always @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			prio_a_q  <= `IPC_RST_PRIO_A;
			prio_b_q  <= `IPC_RST_PRIO_B;
			prio_c_q  <= `IPC_RST_PRIO_C;
			prio_d_q  <= `IPC_RST_PRIO_DE;
			prio_e_q  <= `IPC_RST_PRIO_DE;
			main_q    <= `IPC_RST_MAIN;
			second_q  <= `IPC_RST_SECOND;
			third_q   <= `IPC_RST_THIRD;
			pin_chg_q <= `IPC_RST_PIN_CHG;
			cfg_q     <= `IPC_RST_CFG;
		end else begin
			prio_a_q  <= wmerge(prio_a_q, avs_writedata_i[7:0], `IPC_MSK_PRIO_A,
				wr_en && (avs_address_i == `IPC_OFS_PRIO_A));
			prio_b_q  <= wmerge(prio_b_q, avs_writedata_i[7:0], 8'hFF,
				wr_en && (avs_address_i == `IPC_OFS_PRIO_B));
			prio_c_q  <= wmerge(prio_c_q, avs_writedata_i[7:0], 8'hFF,
				wr_en && (avs_address_i == `IPC_OFS_PRIO_C));
			prio_d_q  <= wmerge(prio_d_q, avs_writedata_i[7:0], `IPC_MSK_PRIO_DE,
				wr_en && (avs_address_i == `IPC_OFS_PRIO_D));
			prio_e_q  <= wmerge(prio_e_q, avs_writedata_i[7:0], `IPC_MSK_PRIO_DE,
				wr_en && (avs_address_i == `IPC_OFS_PRIO_E));
			second_q  <= wmerge(second_q, avs_writedata_i[7:0], `IPC_MSK_SECOND,
				wr_en && (avs_address_i == `IPC_OFS_SECOND));
			pin_chg_q <= wmerge(pin_chg_q, avs_writedata_i[7:0], `IPC_MSK_PIN_CHG,
				wr_en && (avs_address_i == `IPC_OFS_PIN_CHG));
			cfg_q     <= wmerge(cfg_q, avs_writedata_i[7:0], `IPC_MSK_CFG,
				wr_en && (avs_address_i == `IPC_OFS_CFG));
			// flags set by hardware, cleared only by software
			main_q    <= wmerge(main_q, avs_writedata_i[7:0], 8'hFF,
				wr_en && (avs_address_i == `IPC_OFS_MAIN))
				| ({7'h00, ext_hit[0]} << `IPC_MAIN_E0F)
				| ({7'h00, t0_ovf} << `IPC_MAIN_T0F)
				| ({7'h00, |pb_chg} << `IPC_MAIN_PCF);
			third_q   <= wmerge(third_q, avs_writedata_i[7:0], `IPC_MSK_THIRD,
				wr_en && (avs_address_i == `IPC_OFS_THIRD))
				| ({7'h00, ext_hit[1]} << `IPC_THR_E1F)
				| ({7'h00, ext_hit[2]} << `IPC_THR_E2F);
		end
	end

	assign pmode    = cfg_q[`IPC_CFG_PMODE];
	assign gh       = main_q[`IPC_MAIN_GH];
	assign gl       = main_q[`IPC_MAIN_GL];
	assign prio_vec = {prio_e_q[2:0], prio_d_q[2:0], prio_c_q, prio_b_q, prio_a_q[6:0]};
	assign ext_flags = {third_q[`IPC_THR_E2F], third_q[`IPC_THR_E1F], main_q[`IPC_MAIN_E0F]};
	assign ext_ens   = {third_q[`IPC_THR_E2E], third_q[`IPC_THR_E1E], main_q[`IPC_MAIN_E0E]};

	// pin requests gated by their enables
	assign e0_req = ext_flags[0] & ext_ens[0];
	assign e1_req = ext_flags[1] & ext_ens[1];
	assign e2_req = ext_flags[2] & ext_ens[2];
	assign t0_req = main_q[`IPC_MAIN_T0F] & main_q[`IPC_MAIN_T0E];
	assign pc_req = main_q[`IPC_MAIN_PCF] & main_q[`IPC_MAIN_PCE];

	// split by priority bit; pin zero always high
	assign hi_any = e0_req
		| (e1_req & third_q[`IPC_THR_E1P])
		| (e2_req & third_q[`IPC_THR_E2P])
		| (t0_req & second_q[`IPC_SEC_T0P])
		| (pc_req & second_q[`IPC_SEC_PCP])
		| (|(per_req_i & prio_vec));
	assign lo_any = (e1_req & ~third_q[`IPC_THR_E1P])
		| (e2_req & ~third_q[`IPC_THR_E2P])
		| (t0_req & ~second_q[`IPC_SEC_T0P])
		| (pc_req & ~second_q[`IPC_SEC_PCP])
		| (|(per_req_i & ~prio_vec));
	// single level; peripherals need the peripheral enable
	assign one_any = e0_req | e1_req | e2_req | t0_req | pc_req | (gl & (|per_req_i));

	always @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_high_o <= 1'b0;
			irq_low_o  <= 1'b0;
			sleep_q    <= 1'b0;
			snap_q     <= 3'h0;
			wake_o     <= 1'b0;
		end else begin
			// vectoring needs global high enable, also after wake-up
			if (pmode) begin
				irq_high_o <= gh & hi_any;
				irq_low_o  <= gh & gl & lo_any;
			end else begin
				irq_high_o <= gh & one_any;
				irq_low_o  <= 1'b0;
			end
			sleep_q <= sleep_i;
			// enables captured on entry into the low-power mode
			if (sleep_i && !sleep_q) begin
				snap_q <= ext_ens;
			end
			wake_o <= sleep_q & sleep_i & (|(snap_q & ext_ens & ext_flags));
		end
	end

	// return address stack; wraps on overflow like the core stack pointer
	assign sp_dec = sp_q - 1'b1;

	always @(posedge mclk_i) begin
		if (entry_i) begin
			stack_mem[sp_q] <= pc_i;
		end
	end

	always @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sp_q            <= {`IPC_SPW{1'b0}};
			ret_pc_o        <= {`IPC_PCW{1'b0}};
			shadow_working_register_o   <= 8'h00;
			shadow_status_o <= 8'h00;
			shadow_bsr_o    <= 8'h00;
		end else begin
			// push and fast context copy on entry
			if (entry_i) begin
				sp_q            <= sp_q + 1'b1;
				shadow_working_register_o   <= working_register_i;
				shadow_status_o <= status_i;
				shadow_bsr_o    <= bsr_i;
			end else if (return_i) begin
				sp_q     <= sp_dec;
				ret_pc_o <= stack_mem[sp_dec];
			end
		end
	end

endmodule // ipc_top

// >>> test/ipc_chk_sva.sv
// Checker for bus timing, reserved bits and context copy
`timescale 1ns/10ps
`include "ipc_regs.vh"

module ipc_chk (
	input wire logic                mclk_i,
	input wire logic                rstn_i,
	input wire logic [7:0]          avs_address_i,
	input wire logic                avs_read_i,
	input wire logic                avs_write_i,
	input wire logic [31:0]         avs_readdata_o,
	input wire logic                avs_waitrequest_o,
	input wire logic                entry_i,
	input wire logic                return_i,
	input wire logic [`IPC_PCW-1:0] pc_i,
	input wire logic [7:0]          working_register_i,
	input wire logic [7:0]          status_i,
	input wire logic [7:0]          bsr_i,
	input wire logic [`IPC_PCW-1:0] ret_pc_o,
	input wire logic [7:0]          shadow_working_register_o,
	input wire logic [7:0]          shadow_status_o,
	input wire logic [7:0]          shadow_bsr_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rstn_i);
	wire rq = avs_read_i | avs_write_i;
	wire rs = avs_read_i & avs_waitrequest_o;

	wait_one_a: assert property (rq && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("no acknowledge one cycle after request");
	ack_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("acknowledge longer than one cycle");
	ack_cause_a: assert property ($fell(avs_waitrequest_o) |-> $past(rq))
		else $error("acknowledge without request");
	upper_zero_a: assert property (avs_readdata_o[31:8] == 24'h000000)
		else $error("upper read data not zero");
	unmapped_zero_a: assert property (rs && avs_address_i > 8'h28 |=> avs_readdata_o == 32'h00000000)
		else $error("unmapped read not zero");
	top_bit_a: assert property (rs && avs_address_i == 8'h00 |=> !avs_readdata_o[7])
		else $error("group A bit 7 not zero");
	resv_bits_a: assert property (rs && avs_address_i inside {8'h0C, 8'h10} |=> avs_readdata_o[7:3] == 5'h00)
		else $error("groups D or E upper bits not zero");
	shadow_copy_a: assert property (entry_i |=> {shadow_working_register_o, shadow_status_o, shadow_bsr_o} == $past({working_register_i, status_i, bsr_i}))
		else $error("shadow copy wrong");
	pop_pc_a: assert property (entry_i && !return_i ##1 return_i && !entry_i |=> ret_pc_o == $past(pc_i, 2))
		else $error("popped return address wrong");
endmodule // ipc_chk

// >>> test/ipc_tb_top.sv
// Self-checking bench for the interrupt priority block
`timescale 1ns/10ps

module ipc_tb_top;
	logic        mclk_i, rstn_i, rd, wt, ld, ent, ret, slp, ih, il, wk, wq;
	logic [7:0]  ad, q8, shw;
	logic [31:0] wd, rdat;
	logic [2:0]  pin;
	logic [3:0]  prt;
	logic [15:0] tc, tv;
	logic [28:0] per;
	logic [20:0] rpc;
	logic [7:0]  rv [5] = '{8'h7F, 8'hFF, 8'h00, 8'h00, 8'h00};
	logic [7:0]  wm [5] = '{8'h7F, 8'hFF, 8'hFF, 8'h07, 8'h07};
	int          fails, n_tests, cyc = 0;

	ipc_top ipc_top_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .avs_address_i(ad), .avs_read_i(rd),
		.avs_write_i(wt), .avs_writedata_i(wd), .avs_readdata_o(rdat), .avs_waitrequest_o(wq),
		.ext_pin_i(pin), .port_hi_i(prt), .timer_count_i(tc), .per_req_i(per), .sleep_i(slp),
		.entry_i(ent), .return_i(ret), .pc_i(21'h12345), .working_register_i(8'hA5), .status_i(8'h3C),
		.bsr_i(8'h0F), .irq_high_o(ih), .irq_low_o(il), .wake_o(wk), .ret_pc_o(rpc),
		.shadow_working_register_o(shw), .shadow_status_o(), .shadow_bsr_o());
	ipc_tmr_model ipc_tmr_model_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .load_i(ld),
		.load_val_i(tv), .count_o(tc));

	initial begin
		mclk_i = 1'b0;
		forever #12.5 mclk_i = ~mclk_i;
	end
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			fails++;
			complete_run;
		end
	end

	task complete_run;
		if (fails == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Holds the request until waitrequest is seen low
	task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge mclk_i);
		rd <= !w;
		wt <= w;
		ad <= a;
		wd <= {24'h000000, d};
		do begin
			@(posedge mclk_i);
			n++;
		end while (wq !== 1'b0 && n < 20);
		q8 = rdat[7:0];
		rd <= 1'b0;
		wt <= 1'b0;
		if (n >= 20) begin
			fails++;
			complete_run;
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask
	task rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		check(q8 & m, e);
	endtask
	task irq(input logic [1:0] e);
		repeat (3) @(posedge mclk_i);
		check({ih, il}, e);
	endtask
	// Pins go through a two-flop synchroniser, so allow six edges
	task pn(input logic [2:0] p, input logic [3:0] b);
		pin <= p;
		prt <= b;
		repeat (6) @(posedge mclk_i);
	endtask
	task tl(input logic [15:0] v);
		ld <= 1'b1;
		tv <= v;
		@(posedge mclk_i);
		ld <= 1'b0;
	endtask

	task t_regs;
		for (int i = 0; i < 5; i++) begin
			rdc(8'(i * 4), 8'hFF, rv[i]);
			wr(8'(i * 4), 8'hFF);
			rdc(8'(i * 4), 8'hFF, wm[i]);
		end
		wr(8'h40, 8'hFF);
		rdc(8'h40, 8'hFF, 8'h00);
	endtask
	task t_prio;
		wr(8'h24, 8'h80);
		wr(8'h14, 8'hC0);
		per <= 29'h1;
		irq(2'b10);
		wr(8'h00, 8'h00);
		irq(2'b01);
		wr(8'h24, 8'h00);
		irq(2'b10);
		wr(8'h14, 8'h80);
		irq(2'b00);
		per <= 29'h0;
	endtask
	task t_ext;
		wr(8'h24, 8'h80);
		wr(8'h14, 8'h90);
		pn(3'b001, 4'h0);
		rdc(8'h14, 8'h02, 8'h02);
		irq(2'b10);
		wr(8'h14, 8'hD0);
		irq(2'b00);
		wr(8'h18, 8'h55);
		wr(8'h1C, 8'h00);
		pn(3'b011, 4'h0);
		rdc(8'h1C, 8'h01, 8'h00);
		pn(3'b001, 4'h0);
		rdc(8'h1C, 8'h01, 8'h01);
		irq(2'b00);
		wr(8'h1C, 8'h09);
		irq(2'b01);
		wr(8'h1C, 8'h49);
		irq(2'b10);
		wr(8'h1C, 8'h00);
		pn(3'b000, 4'h0);
	endtask
	task t_tmr;
		tl(16'h00F0);
		wr(8'h14, 8'hA0);
		repeat (20) @(posedge mclk_i);
		rdc(8'h14, 8'h04, 8'h04);
		irq(2'b10);
		wr(8'h24, 8'h81);
		tl(16'h00F0);
		wr(8'h14, 8'hA0);
		repeat (20) @(posedge mclk_i);
		rdc(8'h14, 8'h04, 8'h00);
		tl(16'hFFF0);
		repeat (20) @(posedge mclk_i);
		rdc(8'h14, 8'h04, 8'h04);
		wr(8'h18, 8'h71);
		wr(8'h14, 8'hE4);
		irq(2'b01);
		wr(8'h14, 8'h00);
		wr(8'h24, 8'h00);
	endtask
	task t_port;
		wr(8'h24, 8'h80);
		wr(8'h20, 8'h80);
		wr(8'h14, 8'h88);
		pn(3'b000, 4'h1);
		irq(2'b00);
		pn(3'b000, 4'h9);
		rdc(8'h14, 8'h01, 8'h01);
		irq(2'b10);
		wr(8'h18, 8'h70);
		wr(8'h14, 8'hC9);
		irq(2'b01);
		wr(8'h14, 8'h00);
		wr(8'h24, 8'h00);
	endtask
	task t_wake;
		wr(8'h14, 8'h10);
		slp <= 1'b1;
		@(posedge mclk_i);
		pn(3'b001, 4'h9);
		check(wk, 1'b1);
		check(ih, 1'b0);
		wr(8'h14, 8'h92);
		irq(2'b10);
		slp <= 1'b0;
	endtask
	task t_ctx;
		ent <= 1'b1;
		@(posedge mclk_i);
		ent <= 1'b0;
		ret <= 1'b1;
		@(posedge mclk_i);
		ret <= 1'b0;
		@(posedge mclk_i);
		check(shw, 8'hA5);
		check(rpc, 21'h12345);
	endtask

	initial begin
		{rd, wt, ld, ent, ret, slp} = 6'h00;
		ad = 8'h00;
		wd = 32'h00000000;
		pin = 3'h0;
		prt = 4'h0;
		per = 29'h0;
		tv = 16'h0000;
		fails = 0;
		n_tests = 0;
		rstn_i = 1'b0;
		repeat (6) @(posedge mclk_i);
		rstn_i <= 1'b1;
		t_regs;
		t_prio;
		t_ext;
		t_tmr;
		t_port;
		t_wake;
		t_ctx;
		complete_run;
	end
endmodule // ipc_tb_top

bind ipc_top ipc_chk ipc_chk_inst (.mclk_i(mclk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
	.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o), .entry_i(entry_i), .return_i(return_i), .pc_i(pc_i),
	.working_register_i(working_register_i), .status_i(status_i), .bsr_i(bsr_i), .ret_pc_o(ret_pc_o),
	.shadow_working_register_o(shadow_working_register_o), .shadow_status_o(shadow_status_o), .shadow_bsr_o(shadow_bsr_o));

// >>> test/ipc_tmr_model.sv
// Timer-zero model: a same-clock counter that can be loaded
`timescale 1ns/10ps

module ipc_tmr_model (
	input  wire logic        mclk_i,
	input  wire logic        rstn_i,
	input  wire logic        load_i,
	input  wire logic [15:0] load_val_i,
	output logic      [15:0] count_o
);
	// Free-running, so wraps also land in scenarios that never load it
	always @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i)
			count_o <= 16'h0000;
		else if (load_i)
			count_o <= load_val_i;
		else
			count_o <= count_o + 16'h0001;
	end
endmodule // ipc_tmr_model
